// >>> include/adcf_regs.svh
/*
  Register offsets, field positions, reset values and access codes of the
  converter flow configuration block.
  Assumes a word-addressed register port with 16-bit data.
*/
`ifndef ADCF_REGS_SVH
`define ADCF_REGS_SVH

`define ADCF_OFS_MAIN 3'h0
`define ADCF_OFS_AUX 3'h1
`define ADCF_OFS_FLOW 3'h5
`define ADCF_OFS_CMD 3'h6

`define ADCF_MAIN_HI 15
`define ADCF_MAIN_LO 8
`define ADCF_AUX_HI 7
`define ADCF_AUX_LO 4
`define ADCF_FLOW_HI 7
`define ADCF_FLOW_LO 4

`define ADCF_FLW_SEQUENCE_ABORT_REQUEST 3
`define ADCF_FLW_TRIGGER_REQUEST 2
`define ADCF_FLW_RESTART_REQUEST 1
`define ADCF_FLW_LIST_LOAD_OK 0

`define ADCF_MAIN_RST 8'h00
`define ADCF_BMOD_RST 2'h0
`define ADCF_BIT_RST 1'h0
`define ADCF_FLOW_RST 4'h0
`define ADCF_RSV8 8'h00
`define ADCF_RSV4 4'h0
`define ADCF_DATA_RST 16'h0000

`define ADCF_ACC_NONE 2'h0
`define ADCF_ACC_IFC 2'h1
`define ADCF_ACC_BUS 2'h2
`define ADCF_ACC_BOTH 2'h3

`endif

// >>> include/adcf_pkg.sv
/*
  Types of the converter flow configuration block.
  Assumes the field layout given in adcf_regs.svh.
*/
package adcf_pkg;

  typedef struct packed {
    logic en;
    logic soft_rst;
    logic freeze;
    logic wait_halt_select;
    logic [1:0] flow_access_config;
    logic store_on_abort;
    logic flow_mode_select;
  } adcf_main_t;

  typedef struct packed {
    logic command_list_buffer_mode;
    logic result_list_buffer_mode;
    logic special_access_enable;
    logic auto_restart_enable;
  } adcf_aux_t;

  typedef struct packed {
    logic sequence_abort_request;
    logic trigger_request;
    logic restart_request;
    logic list_load_ok;
  } adcf_flow_t;

  typedef struct packed {
    logic conv_active;
    logic last_conv;
    logic list_done;
  } adcf_seq_t;

  typedef struct packed {
    logic store;
    logic discard;
    logic err_set;
    logic sequence_abort_request_set;
  } adcf_dec_t;

endpackage

// >>> logic/adcf_guard_reg.sv
/*
  A configuration field that takes a write only while its condition holds.
  Assumes write, condition and clear come from logic on the same clock.
*/
`timescale 1ns/1ps

module adcf_guard_reg #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic allow_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // A refused write is dropped silently; software learns it only by reading back.
  always_comb begin
    q_next = q_reg;
    if (clr_i) begin
      q_next = RST;
    end else if (wr_i && allow_i) begin
      q_next = d_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_reg <= RST;
    end else if (ce_i) begin
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;

  refused_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && !clr_i && !(wr_i && allow_i) |=> $stable(q_reg))
    else $error("Guarded field changed without an allowed write.");

endmodule // adcf_guard_reg

// >>> logic/adcf_abort_ctl.sv
/*
  Decides result storage and restart error on abort and restart events.
  Assumes the sequencer reports conversion state on the same clock.
*/
`timescale 1ns/1ps

module adcf_abort_ctl import adcf_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic store_on_abort_i,
  input wire logic sequence_abort_request_active_i,
  input wire logic abort_evt_i,
  input wire logic restart_evt_i,
  input wire adcf_seq_t seq_i,
  output adcf_dec_t dec_o
);

  adcf_dec_t dec_reg;
  adcf_dec_t dec_next;
  logic any_evt;
  logic rst_only;
  logic in_final;

  always_comb begin
    any_evt = (abort_evt_i || restart_evt_i) && seq_i.conv_active;
    rst_only = restart_evt_i && !abort_evt_i && !sequence_abort_request_active_i && !seq_i.list_done;
    in_final = seq_i.conv_active && seq_i.last_conv;
    dec_next.store = any_evt && store_on_abort_i;
    dec_next.discard = any_evt && !store_on_abort_i;
    // Storing mode forgives a restart that lands in the last conversion.
    dec_next.err_set = rst_only && (!store_on_abort_i || !in_final);
    dec_next.sequence_abort_request_set = dec_next.err_set;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dec_reg <= '0;
    end else if (ce_i) begin
      dec_reg <= dec_next;
    end
  end

  assign dec_o = dec_reg;

  discard_path_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && any_evt && !store_on_abort_i |=> dec_reg.discard && !dec_reg.store)
    else $error("Aborted result was not discarded.");

  store_path_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && any_evt && store_on_abort_i |=> dec_reg.store && !dec_reg.discard)
    else $error("Aborted result was not stored.");

  early_err_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && rst_only && !store_on_abort_i |=> dec_reg.err_set && dec_reg.sequence_abort_request_set)
    else $error("Early restart did not raise the error.");

  final_ok_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && restart_evt_i && store_on_abort_i && in_final |=> !dec_reg.err_set)
    else $error("Restart in last conversion raised an error.");

  store_err_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && rst_only && store_on_abort_i && !in_final |=> dec_reg.err_set && dec_reg.sequence_abort_request_set)
    else $error("Early restart in storing mode raised no error.");

endmodule // adcf_abort_ctl

// >>> logic/adcf_flow_cfg.sv
/*
  Flow configuration of the converter: control registers, flow request bits,
  access paths, special access, auto restart and abort decisions.
  Assumes bus, internal interface, mode and sequencer inputs all run on
  ref_clk_i, so none of them is synchronised here.
*/
// Behaviour
// - No-store abort discards result, no complete flag
// - No-store early restart flags error, sets abort
// - Store mode keeps aborted result and flags
// - Store mode: restart in last conversion, no error
// - Store mode: early restart flags error, sets abort
// - Flow mode bit picks restart or trigger; here it is only stored and shown on main_o
// - Access config selects none, interface, bus, both
// - Command list single or double buffering
// - Result list single or double buffering
// - Buffer modes writable if disabled or special
// - Special access writable only in special mode
// - Special access clears on special mode exit
// - Special access lifts write restrictions
// - Special access lets bus write unstarted command
// - Auto restart after stop or halting wait exit
// - Auto restart bit writable at any time
// - Wait halt stops conversion in wait mode
`timescale 1ns/1ps
`include "adcf_regs.svh"

module adcf_flow_cfg import adcf_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic bus_sel_i,
  input wire logic bus_we_i,
  input wire logic [2:0] bus_addr_i,
  input wire logic [15:0] bus_wdata_i,
  output logic [15:0] bus_rdata_o,
  input wire logic ifc_we_i,
  input wire adcf_flow_t ifc_wdata_i,
  input wire adcf_flow_t flow_done_i,
  input wire adcf_seq_t seq_i,
  input wire logic err_clr_i,
  input wire logic cmd_started_i,
  input wire logic special_mode_i,
  input wire logic stop_mode_i,
  input wire logic wait_mode_i,
  output adcf_main_t main_o,
  output adcf_aux_t aux_o,
  output adcf_flow_t flow_o,
  output adcf_dec_t dec_o,
  output logic restart_error_flag_o,
  output logic cmd_wr_o,
  output logic [15:0] cmd_wdata_o,
  output logic conv_halt_o
);

  //////////////////////////////////////////////////////////////////////////////

  logic wr_main;
  logic wr_aux;
  logic wr_flow;
  logic wr_cmd;
  logic rd;
  logic en_run;
  adcf_main_t main_reg;
  adcf_main_t main_next;
  adcf_main_t main_wd;
  adcf_aux_t aux_wd;
  adcf_aux_t aux_q;
  logic [1:0] bmod_q;
  logic [1:0] bmod_wd;
  logic smod_q;
  logic smod_wd;
  logic auto_q;
  logic auto_wd;
  logic mode_wd;
  logic bmod_allow;
  logic [3:0] flow_reg;
  logic [3:0] flow_next;
  logic [3:0] flow_set;
  logic [3:0] bus_bits;
  logic [3:0] ifc_bits;
  logic abort_evt;
  logic restart_evt;
  logic auto_evt;
  logic stop_d_reg;
  logic stop_d_next;
  logic wait_d_reg;
  logic wait_d_next;
  logic err_reg;
  logic err_next;
  logic cmd_wr_reg;
  logic cmd_wr_next;
  logic [15:0] cmd_wdata_reg;
  logic [15:0] cmd_wdata_next;
  logic halt_reg;
  logic halt_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  adcf_dec_t dec;

  assign wr_main = bus_sel_i && bus_we_i && (bus_addr_i == `ADCF_OFS_MAIN);
  assign wr_aux = bus_sel_i && bus_we_i && (bus_addr_i == `ADCF_OFS_AUX);
  assign wr_flow = bus_sel_i && bus_we_i && (bus_addr_i == `ADCF_OFS_FLOW);
  assign wr_cmd = bus_sel_i && bus_we_i && (bus_addr_i == `ADCF_OFS_CMD);
  assign rd = bus_sel_i && !bus_we_i;
  assign main_wd = adcf_main_t'(bus_wdata_i[`ADCF_MAIN_HI:`ADCF_MAIN_LO]);
  assign aux_wd = adcf_aux_t'(bus_wdata_i[`ADCF_AUX_HI:`ADCF_AUX_LO]);
  assign bmod_wd = {aux_wd.command_list_buffer_mode, aux_wd.result_list_buffer_mode};
  assign smod_wd = aux_wd.special_access_enable;
  assign auto_wd = aux_wd.auto_restart_enable;
  assign mode_wd = main_wd.flow_mode_select;
  assign en_run = main_reg.en && !main_reg.soft_rst;

  //////////////////////////////////////////////////////////////////////////////
  // Main control register. The soft reset bit lives for one cycle only.

  always_comb begin
    main_next = main_reg;
    main_next.soft_rst = 1'b0;
    if (wr_main) begin
      main_next = main_wd;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      main_reg <= adcf_main_t'(`ADCF_MAIN_RST);
    end else if (ce_i) begin
      main_reg <= main_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Auxiliary register fields, each with its own write condition.

  assign bmod_allow = !main_reg.en || smod_q;

  adcf_guard_reg #(.W(2), .RST(`ADCF_BMOD_RST)) u_bmod (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .clr_i(1'b0),
    .wr_i(wr_aux),
    .allow_i(bmod_allow),
    .d_i(bmod_wd),
    .q_o(bmod_q)
  );

  adcf_guard_reg #(.W(1), .RST(`ADCF_BIT_RST)) u_smod (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .clr_i(!special_mode_i),
    .wr_i(wr_aux),
    .allow_i(special_mode_i),
    .d_i(smod_wd),
    .q_o(smod_q)
  );

  adcf_guard_reg #(.W(1), .RST(`ADCF_BIT_RST)) u_auto (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .clr_i(1'b0),
    .wr_i(wr_aux),
    .allow_i(1'b1),
    .d_i(auto_wd),
    .q_o(auto_q)
  );

  assign aux_q = adcf_aux_t'({bmod_q, smod_q, auto_q});

  //////////////////////////////////////////////////////////////////////////////
  // Low-power exit detection for the automatic restart.

  always_comb begin
    stop_d_next = stop_mode_i;
    wait_d_next = wait_mode_i;
    auto_evt = auto_q && main_reg.en &&
               ((stop_d_reg && !stop_mode_i) ||
                (wait_d_reg && !wait_mode_i && main_reg.wait_halt_select));
    halt_next = wait_mode_i && main_reg.wait_halt_select;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stop_d_reg <= 1'b0;
      wait_d_reg <= 1'b0;
      halt_reg <= 1'b0;
    end else if (ce_i) begin
      stop_d_reg <= stop_d_next;
      wait_d_reg <= wait_d_next;
      halt_reg <= halt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flow request bits. Writing zero has no effect; the sequencer clears a bit
  // once it has acted on it, and a new set in that cycle wins.

  always_comb begin
    bus_bits = `ADCF_FLOW_RST;
    ifc_bits = `ADCF_FLOW_RST;
    if (wr_flow && main_reg.flow_access_config[1]) begin
      bus_bits = bus_wdata_i[`ADCF_FLOW_HI:`ADCF_FLOW_LO];
    end
    if (ifc_we_i && main_reg.flow_access_config[0]) begin
      ifc_bits = ifc_wdata_i;
    end
    flow_set = bus_bits | ifc_bits;
    flow_set[`ADCF_FLW_SEQUENCE_ABORT_REQUEST] = flow_set[`ADCF_FLW_SEQUENCE_ABORT_REQUEST] | dec.sequence_abort_request_set;
    flow_set[`ADCF_FLW_RESTART_REQUEST] = flow_set[`ADCF_FLW_RESTART_REQUEST] | auto_evt;
    flow_next = `ADCF_FLOW_RST;
    if (en_run) begin
      flow_next = (flow_reg & ~flow_done_i) | flow_set;
    end
    abort_evt = en_run && flow_set[`ADCF_FLW_SEQUENCE_ABORT_REQUEST] && !flow_reg[`ADCF_FLW_SEQUENCE_ABORT_REQUEST];
    restart_evt = en_run && flow_set[`ADCF_FLW_RESTART_REQUEST] && !flow_reg[`ADCF_FLW_RESTART_REQUEST];
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flow_reg <= `ADCF_FLOW_RST;
    end else if (ce_i) begin
      flow_reg <= flow_next;
    end
  end

  adcf_abort_ctl u_abort (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .store_on_abort_i(main_reg.store_on_abort),
    .sequence_abort_request_active_i(flow_reg[`ADCF_FLW_SEQUENCE_ABORT_REQUEST]),
    .abort_evt_i(abort_evt),
    .restart_evt_i(restart_evt),
    .seq_i(seq_i),
    .dec_o(dec)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Restart error flag, current command forwarding and read data.

  always_comb begin
    err_next = dec.err_set || (err_reg && !err_clr_i && en_run);
    cmd_wr_next = wr_cmd && smod_q && !cmd_started_i;
    cmd_wdata_next = cmd_wr_next ? bus_wdata_i : cmd_wdata_reg;
    rdata_next = `ADCF_DATA_RST;
    if (rd) begin
      case (bus_addr_i)
        `ADCF_OFS_MAIN: rdata_next = {main_reg, `ADCF_RSV8};
        `ADCF_OFS_AUX: rdata_next = {`ADCF_RSV8, aux_q, `ADCF_RSV4};
        `ADCF_OFS_FLOW: rdata_next = {`ADCF_RSV8, flow_reg, `ADCF_RSV4};
        default: rdata_next = `ADCF_DATA_RST;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_reg <= 1'b0;
      cmd_wr_reg <= 1'b0;
      cmd_wdata_reg <= `ADCF_DATA_RST;
      rdata_reg <= `ADCF_DATA_RST;
    end else if (ce_i) begin
      err_reg <= err_next;
      cmd_wr_reg <= cmd_wr_next;
      cmd_wdata_reg <= cmd_wdata_next;
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata_o = rdata_reg;
  assign main_o = main_reg;
  assign aux_o = aux_q;
  assign flow_o = adcf_flow_t'(flow_reg);
  assign dec_o = dec;
  assign restart_error_flag_o = err_reg;
  assign cmd_wr_o = cmd_wr_reg;
  assign cmd_wdata_o = cmd_wdata_reg;
  assign conv_halt_o = halt_reg;

  //////////////////////////////////////////////////////////////////////////////

  bmod_lock_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && wr_aux && main_reg.en && !smod_q |=> $stable(bmod_q))
    else $error("Buffer mode changed while locked.");

  bmod_open_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && wr_aux && (!main_reg.en || smod_q) |=> bmod_q == $past(bmod_wd))
    else $error("Buffer mode write was lost.");

  smod_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && wr_aux && special_mode_i |=> smod_q == $past(smod_wd))
    else $error("Special access write mishandled.");

  smod_exit_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && !special_mode_i |=> !smod_q)
    else $error("Special access survived special mode exit.");

  auto_wr_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && wr_aux |=> auto_q == $past(auto_wd))
    else $error("Auto restart write was lost.");

  auto_evt_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && auto_evt && en_run |=> flow_reg[`ADCF_FLW_RESTART_REQUEST])
    else $error("Auto restart did not raise a restart.");

  cmd_wr_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && wr_cmd |=> cmd_wr_reg == $past(smod_q && !cmd_started_i))
    else $error("Command write gating is wrong.");

  halt_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && wait_mode_i && main_reg.wait_halt_select |=> conv_halt_o)
    else $error("Wait halt not raised.");

  acc_none_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && flow_reg == `ADCF_FLOW_RST && main_reg.flow_access_config == `ADCF_ACC_NONE &&
    !dec.sequence_abort_request_set && !auto_evt |=> flow_reg == `ADCF_FLOW_RST)
    else $error("Flow bit set with no access path.");

  err_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && dec.err_set |=> restart_error_flag_o)
    else $error("Restart error flag not raised.");

  mode_wr_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ce_i && wr_main |=> main_o.flow_mode_select == $past(mode_wd))
    else $error("Flow mode write was lost.");

endmodule // adcf_flow_cfg

// >>> bench/adcf_seq_model.sv
/*
  Partner model: the sequencer beside the flow block; the bench drives the internal interface itself.
  Assumes the bench commands the sequencer state; bits are retired after a service time.
*/
`timescale 1ns/1ps

module adcf_seq_model import adcf_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic slow_i,
  input wire adcf_seq_t state_i,
  input wire adcf_flow_t flow_i,
  output adcf_seq_t seq_o,
  output adcf_flow_t flow_done_o
);
  logic [3:0] age_reg [4];

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seq_o <= '0;
      age_reg <= '{default: 4'h0};
    end else begin
      seq_o <= state_i;
      for (int b = 0; b < 4; b++) begin
        age_reg[b] <= flow_i[b] ? age_reg[b] + 4'h1 : 4'h0;
      end
    end
  end

  // A request is retired only after it has stood its service time, so short checks still see it.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      flow_done_o[b] = age_reg[b] >= (slow_i ? 4'h8 : 4'h3);
    end
  end
endmodule // adcf_seq_model

// >>> bench/adcf_flow_cfg_bench.sv
/*
  Self-checking bench of the flow configuration block.
  Assumes one 20 MHz clock; inputs change at the falling edge.
*/
`timescale 1ns/1ps
`include "adcf_regs.svh"

`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end

module adcf_flow_cfg_bench import adcf_pkg::*;;
  logic ref_clk_i, rstn_i, ce_i, bus_sel_i, bus_we_i, ifc_we_i, err_clr_i, cmd_started_i;
  logic special_mode_i, stop_mode_i, wait_mode_i, restart_error_flag_o, cmd_wr_o, conv_halt_o, slow;
  logic [2:0] bus_addr_i;
  logic [15:0] bus_wdata_i, bus_rdata_o, cmd_wdata_o, d;
  adcf_flow_t ifc_wdata_i, flow_done_i, flow_o;
  adcf_seq_t seq_i, seq_cmd;
  adcf_main_t main_o;
  adcf_aux_t aux_o;
  adcf_dec_t dec_o;
  logic [31:0] rng;
  int errors, cmp_count;
  logic soa, rst, err;

  adcf_flow_cfg adcf_flow_cfg_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .bus_sel_i(bus_sel_i), .bus_we_i(bus_we_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
    .bus_rdata_o(bus_rdata_o), .ifc_we_i(ifc_we_i), .ifc_wdata_i(ifc_wdata_i),
    .flow_done_i(flow_done_i), .seq_i(seq_i), .err_clr_i(err_clr_i), .cmd_started_i(cmd_started_i),
    .special_mode_i(special_mode_i), .stop_mode_i(stop_mode_i), .wait_mode_i(wait_mode_i),
    .main_o(main_o), .aux_o(aux_o), .flow_o(flow_o), .dec_o(dec_o),
    .restart_error_flag_o(restart_error_flag_o), .cmd_wr_o(cmd_wr_o), .cmd_wdata_o(cmd_wdata_o),
    .conv_halt_o(conv_halt_o));

  adcf_seq_model adcf_seq_model_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .slow_i(slow),
    .state_i(seq_cmd), .flow_i(flow_o), .seq_o(seq_i), .flow_done_o(flow_done_i));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic [15:0] mw(input logic en, input logic wh, input logic [1:0] acc,
                                      input logic s, input logic md);
    return {en, 2'b00, wh, acc, s, md, 8'h00};
  endfunction

  // Decision pulses {store, discard, err_set, sequence_abort_request_set} expected for one event.
  function automatic logic [3:0] exp_dec(input logic s, input logic r, input adcf_seq_t q);
    logic e;
    e = r & !q.list_done & (!s | !(q.conv_active & q.last_conv));
    return {q.conv_active & s, q.conv_active & !s, e, e};
  endfunction

  task automatic bus_wr(input logic [2:0] a, input logic [15:0] v);
    @(negedge ref_clk_i);
    bus_sel_i = 1'b1;
    bus_we_i = 1'b1;
    bus_addr_i = a;
    bus_wdata_i = v;
    @(negedge ref_clk_i);
    bus_sel_i = 1'b0;
    bus_we_i = 1'b0;
  endtask

  task automatic bus_rd(input logic [2:0] a, input logic [15:0] ex);
    @(negedge ref_clk_i);
    bus_sel_i = 1'b1;
    bus_addr_i = a;
    @(negedge ref_clk_i);
    bus_sel_i = 1'b0;
    `CHK("read data", ex, bus_rdata_o)
  endtask

  task automatic ifc_wr(input logic [3:0] v);
    @(negedge ref_clk_i);
    ifc_we_i = 1'b1;
    ifc_wdata_i = v;
    @(negedge ref_clk_i);
    ifc_we_i = 1'b0;
  endtask

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    errors++;
    $display("BAD watchdog expected end seen hang");
    finish_test();
  end

  initial begin
    {rstn_i, bus_sel_i, bus_we_i, ifc_we_i, err_clr_i, cmd_started_i, slow} = '0;
    {special_mode_i, stop_mode_i, wait_mode_i, bus_addr_i, bus_wdata_i, ifc_wdata_i, seq_cmd} = '0;
    ce_i = 1'b1;
    rng = 32'h0000_b365;
    errors = 0;
    cmp_count = 0;
    repeat (20) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rstn_i = 1'b1;
    @(negedge ref_clk_i);
    `CHK("main reset", `ADCF_MAIN_RST, main_o)
    `CHK("aux reset", 4'h0, aux_o)
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      bus_wr(`ADCF_OFS_MAIN, {rng[7:0] & 8'hbf, 8'h00});
      `CHK("main", rng[7:0] & 8'hbf, main_o)
      bus_rd(`ADCF_OFS_MAIN, {rng[7:0] & 8'hbf, 8'h00});
    end
    ce_i = 1'b0;
    bus_wr(`ADCF_OFS_MAIN, mw(1'b0, 1'b0, 2'h3, 1'b1, 1'b1));
    `CHK("main frozen", rng[7:0] & 8'hbf, main_o)
    ce_i = 1'b1;
    bus_rd(3'h7, 16'h0000);
    // Buffer modes, special access and auto restart under their own write conditions.
    bus_wr(`ADCF_OFS_MAIN, mw(1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
    bus_wr(`ADCF_OFS_AUX, 16'h00c0);
    `CHK("aux", 4'hc, aux_o)
    bus_wr(`ADCF_OFS_MAIN, mw(1'b1, 1'b0, 2'h0, 1'b0, 1'b0));
    bus_wr(`ADCF_OFS_AUX, 16'h0030);
    `CHK("aux", 4'hd, aux_o)
    special_mode_i = 1'b1;
    bus_wr(`ADCF_OFS_AUX, 16'h0020);
    `CHK("aux", 4'he, aux_o)
    bus_wr(`ADCF_OFS_AUX, 16'h0020);
    `CHK("aux", 4'h2, aux_o)
    rng = xs(rng);
    d = rng[15:0];
    bus_wr(`ADCF_OFS_CMD, d);
    `CHK("cmd strobe", 1'b1, cmd_wr_o)
    `CHK("cmd data", d, cmd_wdata_o)
    cmd_started_i = 1'b1;
    bus_wr(`ADCF_OFS_CMD, ~d);
    `CHK("cmd strobe", 1'b0, cmd_wr_o)
    `CHK("cmd data", d, cmd_wdata_o)
    cmd_started_i = 1'b0;
    special_mode_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    `CHK("special", 1'b0, aux_o.special_access_enable)
    bus_wr(`ADCF_OFS_CMD, ~d);
    `CHK("cmd strobe", 1'b0, cmd_wr_o)
    // Each access code opens exactly the paths it names.
    for (int a = 0; a < 4; a++) begin
      bus_wr(`ADCF_OFS_MAIN, mw(1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
      bus_wr(`ADCF_OFS_MAIN, mw(1'b1, 1'b0, a[1:0], 1'b0, a[0]));
      ifc_wr(4'h4);
      `CHK("path ifc", a[0], flow_o.trigger_request)
      bus_wr(`ADCF_OFS_MAIN, mw(1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
      bus_wr(`ADCF_OFS_MAIN, mw(1'b1, 1'b0, a[1:0], 1'b0, a[0]));
      bus_wr(`ADCF_OFS_FLOW, 16'h0040);
      `CHK("path bus", a[1], flow_o.trigger_request)
    end
    // Every abort and restart case against every sequencer state.
    for (int i = 0; i < 32; i++) begin
      rng = xs(rng);
      slow = rng[0];
      {soa, rst, seq_cmd} = i[4:0];
      err = |(exp_dec(soa, rst, seq_cmd) & 4'h1);
      bus_wr(`ADCF_OFS_MAIN, mw(1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
      bus_wr(`ADCF_OFS_MAIN, mw(1'b1, 1'b0, 2'h1, soa, rng[1]));
      repeat (2) @(negedge ref_clk_i);
      ifc_wr(rst ? 4'h2 : 4'h8);
      // The decision pulses stand right after the event edge; an error abort repeats store or discard one cycle later.
      `CHK("decision", exp_dec(soa, rst, seq_cmd), dec_o)
      @(negedge ref_clk_i);
      `CHK("restart error", err, restart_error_flag_o)
      `CHK("abort bit", err | !rst, flow_o.sequence_abort_request)
      if (err) begin
        err_clr_i = 1'b1;
        @(negedge ref_clk_i);
        err_clr_i = 1'b0;
        `CHK("error clear", 1'b0, restart_error_flag_o)
      end
      // The slowest service time retires every request inside this wait, a cycle and a half before the check.
      repeat (9) @(negedge ref_clk_i);
      `CHK("retired", 4'h0, flow_o)
    end
    // Automatic restart after stop exit in both flow modes, and after halting wait exit with flow_mode_select clear.
    seq_cmd = 3'h7;
    for (int k = 0; k < 8; k++) begin
      bus_wr(`ADCF_OFS_MAIN, mw(1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
      bus_wr(`ADCF_OFS_MAIN, mw(1'b1, !k[2], 2'h1, 1'b1, k[2]));
      bus_wr(`ADCF_OFS_AUX, {11'h000, k[1], 4'h0});
      @(negedge ref_clk_i);
      stop_mode_i = !k[0];
      wait_mode_i = k[0];
      repeat (2) @(negedge ref_clk_i);
      `CHK("halt", k[0] & !k[2], conv_halt_o)
      stop_mode_i = 1'b0;
      wait_mode_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      `CHK("auto restart", k[1] & (!k[0] | !k[2]), flow_o.restart_request)
    end
    finish_test();
  end
endmodule // adcf_flow_cfg_bench
